// *** pin_source.sv ***
// Partner model: drives timed pulse trains onto the external count pin
`timescale 1ns/1ps
`default_nettype none
module pin_source (
	input  wire logic       ref_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       start_in,
	input  wire logic [7:0] pulses_in,
	output logic            count_input_pin_out
);
	logic [8:0] edges_reg;
	logic [1:0] hold_reg;
	// Each level held four cycles, safely above the two-cycle minimum
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			edges_reg <= 9'h000;
			hold_reg <= 2'h0;
			count_input_pin_out <= 1'b0;
		end else if (start_in) begin
			edges_reg <= {pulses_in, 1'b0};
			hold_reg <= 2'h0;
		end else if (edges_reg != 9'h000) begin
			hold_reg <= hold_reg + 2'h1;
			if (hold_reg == 2'h3) begin
				count_input_pin_out <= ~count_input_pin_out;
				edges_reg <= edges_reg - 9'h001;
			end
		end
	end
endmodule // pin_source
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the prescaled 8-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       gie = 1'b0;
	logic       vec = 1'b0;
	logic       start = 1'b0;
	logic [7:0] pulses = 8'h00;
	logic       pin;
	logic [7:0] rdata;
	logic       irq;
	int         fail_count = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	localparam logic [7:0] CNT = timer_pkg::COUNTER_VALUE_OFS;
	localparam logic [7:0] CTL = timer_pkg::CLOCK_CONTROL_OFS;
	localparam logic [7:0] FLG = timer_pkg::FLAG_REGISTER_OFS;
	localparam logic [7:0] MSK = timer_pkg::MASK_REGISTER_OFS;
	// Rows: select, window in cycles, pin pulses, expected count
	logic [2:0] t_sel [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	int         t_win [8] = '{40, 40, 64, 128, 512, 2048, 60, 60};
	logic [7:0] t_pul [8] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05};
	logic [7:0] t_exp [8] = '{8'h00, 8'h28, 8'h08, 8'h02, 8'h02, 8'h02, 8'h05, 8'h05};
	logic [7:0] ofs [4] = '{CNT, CTL, FLG, MSK};

	timer_counter dut (.ref_clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .count_input_pin_in(pin), .global_irq_enable_in(gie),
		.vector_taken_in(vec), .rdata_out(rdata), .overflow_irq_out(irq));
	pin_source src (.ref_clk_in(clk), .rstn_in(rstn), .start_in(start),
		.pulses_in(pulses), .count_input_pin_out(pin));

	// Clock and hang guard; the longest run is a few thousand cycles
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Idle cycle first so a strobe is never assigned twice in one step
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check8(name, exp, rdata);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		check8("irq in reset", 8'h00, {7'h00, irq});
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd_chk("reset value", ofs[i], 8'h00);
		end
		$display("test reset done");
		// Count window per source; window is a multiple of the divider
		for (int i = 0; i < 8; i++) begin
			pulses <= t_pul[i];
			wr_reg(CTL, {5'h00, t_sel[i]});
			wr_reg(CNT, 8'h00);
			start <= (t_pul[i] != 8'h00);
			repeat (t_win[i] - 1) begin
				@(posedge clk);
				start <= 1'b0;
			end
			rd_chk("count", CNT, t_exp[i]);
			$display("test row %0d done", i);
		end
		// Reserved control bits and an unmapped address
		wr_reg(CTL, 8'hf8);
		rd_chk("control", CTL, 8'h00);
		rd_chk("unmapped", 8'h40, 8'h00);
		// Written value counts on from the next tick
		wr_reg(CTL, 8'h01);
		wr_reg(CNT, 8'h80);
		rd_chk("resume", CNT, 8'h81);
		$display("test write done");
		// Wrap sets the flag; request needs the flag and both enables
		wr_reg(MSK, 8'h02);
		rd_chk("mask", MSK, 8'h02);
		gie <= 1'b1;
		wr_reg(CNT, 8'hfd);
		repeat (4) @(posedge clk);
		wr_reg(CTL, 8'h00);
		#1;
		check8("irq", 8'h01, {7'h00, irq});
		rd_chk("flag", FLG, 8'h02);
		wr_reg(FLG, 8'h00);
		rd_chk("flag kept", FLG, 8'h02);
		gie <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check8("irq masked", 8'h00, {7'h00, irq});
		wr_reg(FLG, 8'h02);
		rd_chk("flag cleared", FLG, 8'h00);
		// Vector taken clears a fresh flag
		wr_reg(CTL, 8'h01);
		wr_reg(CNT, 8'hfd);
		repeat (4) @(posedge clk);
		vec <= 1'b1;
		@(posedge clk);
		vec <= 1'b0;
		wr_reg(CTL, 8'h00);
		rd_chk("vector clear", FLG, 8'h00);
		$display("test overflow done");
		// Reset in mid-run with the counter running and the enable set
		wr_reg(CTL, 8'h01);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd_chk("reset again", ofs[i], 8'h00);
		end
		$display("test mid-run reset done");
		test_done();
	end
endmodule // testbench
`default_nettype wire

// *** timer_counter.sv ***
// Prescaled 8-bit timer/counter with register port and overflow flag
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module timer_counter (
	input  wire logic       ref_clk_in,
	input  wire logic       rstn_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire logic       count_input_pin_in,
	input  wire logic       global_irq_enable_in,
	input  wire logic       vector_taken_in,
	output logic      [7:0] rdata_out,
	output logic            overflow_irq_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [9:0] prescale_reg;
	logic [2:0] pin_sync_reg;
	logic [2:0] select_reg;
	logic [7:0] counter_value_reg;
	logic       overflow_flag_reg;
	logic       overflow_irq_enable_reg;
	logic       pin_level_reg;
	logic       pin_rise;
	logic       pin_fall;
	logic       tick;
	logic       wr_count;
	logic       overflow;
	logic [7:0] rdata_next;

	// Register hit decode, used by both read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	// Free-running so taps stay phase-locked regardless of selection
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prescale_reg <= 10'h000;
		end else begin
			prescale_reg <= prescale_reg + 10'h001;
		end
	end

	// ----------------------------------------------------------------
	// Count pin synchroniser
	// ----------------------------------------------------------------
	// Pin is read straight from the pad, so output mode still counts
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_sync_reg  <= 3'h0;
			pin_level_reg <= 1'b0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], count_input_pin_in};
			// Accept a change only once stages two and three agree
			if (pin_sync_reg[1] == pin_sync_reg[2]) begin
				pin_level_reg <= pin_sync_reg[2];
			end
		end
	end

	assign pin_rise = (pin_sync_reg[1] == pin_sync_reg[2]) && pin_sync_reg[2] && !pin_level_reg;
	assign pin_fall = (pin_sync_reg[1] == pin_sync_reg[2]) && !pin_sync_reg[2] && pin_level_reg;

	// ----------------------------------------------------------------
	// Count enable selection
	// ----------------------------------------------------------------
	always_comb begin
		case (select_reg)
			timer_pkg::SEL_STOP:     tick = 1'b0;
			timer_pkg::SEL_CORE:     tick = 1'b1;
			timer_pkg::SEL_DIV8:     tick = (prescale_reg & timer_pkg::DIV8_MASK) == timer_pkg::DIV8_MASK;
			timer_pkg::SEL_DIV64:    tick = (prescale_reg & timer_pkg::DIV64_MASK) == timer_pkg::DIV64_MASK;
			timer_pkg::SEL_DIV256:   tick = (prescale_reg & timer_pkg::DIV256_MASK) == timer_pkg::DIV256_MASK;
			timer_pkg::SEL_DIV1024:  tick = prescale_reg == timer_pkg::DIV1024_MASK;
			timer_pkg::SEL_PIN_FALL: tick = pin_fall;
			timer_pkg::SEL_PIN_RISE: tick = pin_rise;
			default:                 tick = 1'b0;
		endcase
	end

	assign wr_count = wr_in && hit(addr_in, timer_pkg::COUNTER_VALUE_OFS);
	assign overflow = tick && !wr_count && (counter_value_reg == timer_pkg::COUNTER_TOP);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// A write wins over a tick in the same cycle; counting resumes next tick
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			counter_value_reg <= timer_pkg::COUNTER_RESET;
		end else if (wr_count) begin
			counter_value_reg <= wdata_in;
		end else if (tick) begin
			counter_value_reg <= counter_value_reg + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Control and mask registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			select_reg              <= timer_pkg::SELECT_RESET;
			overflow_irq_enable_reg <= 1'b0;
		end else if (wr_in) begin
			if (hit(addr_in, timer_pkg::CLOCK_CONTROL_OFS)) begin
				select_reg <= wdata_in[timer_pkg::SELECT_WIDTH-1:0];
			end
			if (hit(addr_in, timer_pkg::MASK_REGISTER_OFS)) begin
				overflow_irq_enable_reg <= wdata_in[timer_pkg::OVERFLOW_IRQ_EN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Overflow flag
	// ----------------------------------------------------------------
	// A new overflow wins over any clear in the same cycle
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			overflow_flag_reg <= 1'b0;
		end else if (overflow) begin
			overflow_flag_reg <= 1'b1;
		end else if (vector_taken_in) begin
			overflow_flag_reg <= 1'b0;
		end else if (wr_in && hit(addr_in, timer_pkg::FLAG_REGISTER_OFS)
			&& wdata_in[timer_pkg::OVERFLOW_FLAG_BIT]) begin
			overflow_flag_reg <= 1'b0;
		end
	end

	// Request registered so the output comes from a flip-flop
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			overflow_irq_out <= 1'b0;
		end else begin
			overflow_irq_out <= overflow_flag_reg && overflow_irq_enable_reg
				&& global_irq_enable_in;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped offsets and reserved bits read as zero
	always_comb begin
		rdata_next = 8'h00;
		if (hit(addr_in, timer_pkg::COUNTER_VALUE_OFS)) begin
			rdata_next = counter_value_reg;
		end else if (hit(addr_in, timer_pkg::CLOCK_CONTROL_OFS)) begin
			rdata_next = {5'h00, select_reg};
		end else if (hit(addr_in, timer_pkg::FLAG_REGISTER_OFS)) begin
			rdata_next[timer_pkg::OVERFLOW_FLAG_BIT] = overflow_flag_reg;
		end else if (hit(addr_in, timer_pkg::MASK_REGISTER_OFS)) begin
			rdata_next[timer_pkg::OVERFLOW_IRQ_EN_BIT] = overflow_irq_enable_reg;
		end
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			rdata_out <= rdata_next;
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_top_tick;
		tick && !wr_count && counter_value_reg == 8'hff;
	endsequence

	property p_wrap;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		s_top_tick |=> counter_value_reg == 8'h00 && overflow_flag_reg;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap did not set flag");

	property p_stop_holds;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(select_reg == 3'h0 && !wr_count) |=> $stable(counter_value_reg);
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stopped counter moved");

	property p_core_counts;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(select_reg == 3'h1 && !wr_count) |=> counter_value_reg == $past(counter_value_reg) + 8'h01;
	endproperty
	a_core_counts: assert property (p_core_counts) else $error("core select not counting");

	property p_write_loads;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		wr_count |=> counter_value_reg == $past(wdata_in);
	endproperty
	a_write_loads: assert property (p_write_loads) else $error("count write lost");

	property p_div8_period;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(select_reg == 3'h2 && tick) |=> !tick [*7];
	endproperty
	a_div8_period: assert property (p_div8_period) else $error("divide by 8 tick spacing");

	property p_ctrl_reserved;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(rd_in && addr_in == timer_pkg::CLOCK_CONTROL_OFS) |=> rdata_out[7:3] == 5'h00;
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits nonzero");

	property p_flag_clear;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(wr_in && addr_in == timer_pkg::FLAG_REGISTER_OFS && wdata_in[1] && !overflow)
			|=> !overflow_flag_reg;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by one");

	property p_irq;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		overflow_irq_out == $past(overflow_flag_reg && overflow_irq_enable_reg
			&& global_irq_enable_in);
	endproperty
	a_irq: assert property (p_irq) else $error("irq not following flag and enables");

	property p_pin_rise;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(select_reg == 3'h7 && pin_rise && !wr_count) |=> counter_value_reg != $past(counter_value_reg);
	endproperty
	a_pin_rise: assert property (p_pin_rise) else $error("pin rise not counted");

	property p_pin_fall;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(select_reg == timer_pkg::SEL_PIN_FALL && pin_fall && !wr_count)
			|=> counter_value_reg != $past(counter_value_reg);
	endproperty
	a_pin_fall: assert property (p_pin_fall) else $error("pin fall not counted");

	// Stages two and three must both have seen the new level before an edge counts
	property p_sync_rise;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		pin_rise |-> $past(count_input_pin_in, 2) && $past(count_input_pin_in, 3);
	endproperty
	a_sync_rise: assert property (p_sync_rise) else $error("rise seen before sync");

	property p_sync_fall;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		pin_fall |-> !$past(count_input_pin_in, 2) && !$past(count_input_pin_in, 3);
	endproperty
	a_sync_fall: assert property (p_sync_fall) else $error("fall seen before sync");

	property p_vector_clears;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(vector_taken_in && !overflow) |=> !overflow_flag_reg;
	endproperty
	a_vector_clears: assert property (p_vector_clears) else $error("vector left flag set");

	property p_flag_read;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(rd_in && addr_in == timer_pkg::FLAG_REGISTER_OFS)
			|=> rdata_out[timer_pkg::OVERFLOW_FLAG_BIT] == $past(overflow_flag_reg);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read mismatch");

	// Read data must not linger past its one cycle
	property p_rdata_idle;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		!rd_in |=> rdata_out == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

	property p_count_read;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		(rd_in && addr_in == timer_pkg::COUNTER_VALUE_OFS)
			|=> rdata_out == $past(counter_value_reg);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read mismatch");

	// First edge after release still sees the reset value, hence the guard
	property p_prescale_runs;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		$past(rstn_in) |-> prescale_reg == $past(prescale_reg) + 10'h001;
	endproperty
	a_prescale_runs: assert property (p_prescale_runs) else $error("prescaler not free-running");

endmodule // timer_counter

`default_nettype wire

// *** timer_pkg.sv ***
// Register map, field layout and constants of the prescaled 8-bit timer/counter
package timer_pkg;

	// ----------------------------------------------------------------
	// Register offsets (I/O space byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] COUNTER_VALUE_OFS   = 8'h32;
	localparam logic [7:0] CLOCK_CONTROL_OFS   = 8'h33;
	localparam logic [7:0] FLAG_REGISTER_OFS   = 8'h38;
	localparam logic [7:0] MASK_REGISTER_OFS   = 8'h39;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         SELECT_WIDTH        = 3;
	localparam int         OVERFLOW_FLAG_BIT   = 1;
	localparam int         OVERFLOW_IRQ_EN_BIT = 1;
	localparam logic [7:0] COUNTER_RESET       = 8'h00;
	localparam logic [2:0] SELECT_RESET        = 3'h0;
	localparam logic [7:0] COUNTER_TOP         = 8'hff;

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	localparam int         PRESCALE_WIDTH      = 10;
	localparam logic [9:0] DIV8_MASK           = 10'h007;
	localparam logic [9:0] DIV64_MASK          = 10'h03f;
	localparam logic [9:0] DIV256_MASK         = 10'h0ff;
	localparam logic [9:0] DIV1024_MASK        = 10'h3ff;

	// Clock-select encodings
	localparam logic [2:0] SEL_STOP            = 3'h0;
	localparam logic [2:0] SEL_CORE            = 3'h1;
	localparam logic [2:0] SEL_DIV8            = 3'h2;
	localparam logic [2:0] SEL_DIV64           = 3'h3;
	localparam logic [2:0] SEL_DIV256          = 3'h4;
	localparam logic [2:0] SEL_DIV1024         = 3'h5;
	localparam logic [2:0] SEL_PIN_FALL        = 3'h6;
	localparam logic [2:0] SEL_PIN_RISE        = 3'h7;

endpackage : timer_pkg
